/* wtc_pkg.sv */
// wtc_pkg: constants, register layout and types for the wide timer control block
// Function
// - Writing one to control bit 7 starts the wide counter, zero stops it, and reading it shows whether it runs.
// - In transmit operation the wide counter reloads at terminal count when the pass bit is zero and halts when it is one.
// - Control bit 5 reads one after a wide counter timeout, writing one clears it and writing zero leaves it.
// - Control bits 4 and 3 pick the counter clock as system clock, half, quarter or eighth.
// - Control bit 2 enables or disables the data capture interrupt.
// - Control bit 1 enables or disables the wide counter timeout interrupt.
// - Control bit 0 routes either the port output or the wide timer output onto the shared pin.
// - Power-on reset clears all control fields, and stop recovery keeps the clock select and capture mask fields.
// - In demodulation mode a rising pin edge captures the narrow count into the low capture register, a falling edge into the high one.
// - A capture sets the matching edge status bit of the shared control register and requests an interrupt if narrow bit 2 and wide control bit 2 both allow.
// - After each capture the narrow counter reloads with all ones and keeps counting.
// - When the narrow counter reaches zero in demodulation mode it sets timeout bit 5, may interrupt via bit 1, and goes on from all ones.
package wtc_pkg;
    localparam int unsigned ADDR_W = 6;
    localparam int unsigned DATA_W = 32;
    localparam logic [3:0] IDX_NARROW_CTRL = 4'h0;
    localparam logic [3:0] IDX_SHARED_CTRL = 4'h1;
    localparam logic [3:0] IDX_WIDE_CTRL = 4'h2;
    localparam logic [3:0] IDX_WIDE_INIT = 4'h3;
    localparam logic [3:0] IDX_WIDE_COUNT = 4'h4;
    localparam logic [3:0] IDX_CAPTURE_LOW = 4'h5;
    localparam logic [3:0] IDX_CAPTURE_HIGH = 4'h6;
    localparam logic [3:0] IDX_NARROW_COUNT = 4'h7;
    localparam logic [3:0] IDX_IRQ_STATUS = 4'h8;
    localparam logic [3:0] IDX_IRQ_MASK = 4'h9;
    // byte address bits that hold the register index
    localparam int unsigned IDX_LSB = 2;
    // narrow control register bit positions
    localparam int unsigned NC_RUN = 7;
    localparam int unsigned NC_TIMEOUT = 5;
    localparam int unsigned NC_CAP_IE = 2;
    localparam int unsigned NC_TMO_IE = 1;
    // shared control register bit positions
    localparam int unsigned SC_DEMOD = 6;
    localparam int unsigned SC_RISE = 1;
    localparam int unsigned SC_FALL = 0;
    // interrupt status bit positions
    localparam int unsigned IRQ_WIDE_TMO = 0;
    localparam int unsigned IRQ_CAPTURE = 1;
    localparam int unsigned IRQ_NARROW_TMO = 2;
    localparam int unsigned IRQ_W = 3;
    localparam logic [7:0] NARROW_RELOAD = 8'hff;
    localparam logic [7:0] NARROW_ZERO = 8'h00;
    localparam logic [15:0] WIDE_ZERO = 16'h0000;
    localparam logic [15:0] WIDE_INIT_RST = 16'hffff;
    localparam logic [1:0] PRESCALE_DIV1 = 2'h0;
    localparam logic [1:0] PRESCALE_DIV2 = 2'h1;
    localparam logic [1:0] PRESCALE_DIV4 = 2'h2;

    typedef struct packed {
        logic wide_counter_run;
        logic single_pass;
        logic time_out;
        logic [1:0] counter_prescale_select;
        logic capture_int_mask;
        logic counter_int_mask;
        logic pin_output_select;
    } wtc_wide_ctrl_t;

    localparam wtc_wide_ctrl_t WIDE_CTRL_RST = 8'h00;

    typedef struct packed {
        logic read;
        logic write;
        logic [ADDR_W-1:0] address;
        logic [DATA_W-1:0] writedata;
    } wtc_avmm_req_t;

    // sticky flag update: a set in the clearing cycle wins
    function automatic logic w1c(input logic cur, input logic set, input logic clr);
        return set | (cur & ~clr);
    endfunction
endpackage

/* wtc_prescale.sv */
// wtc_prescale: divides the system clock into a one-cycle counter tick
`timescale 1ns/1ps
`default_nettype none
module wtc_prescale (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [1:0] sel,
    output logic tick
);
    import wtc_pkg::*;
    logic [2:0] div_q;
    logic [2:0] div_d;
    assign div_d = div_q + 3'h1;
    always_ff @(posedge clock) begin
        if (!resetn) begin
            div_q <= 3'h0;
        end else begin
            div_q <= div_d;
        end
    end
    // free-running divider, so a select change takes effect within eight cycles
    assign tick = (sel == PRESCALE_DIV1) ? 1'b1 :
                  (sel == PRESCALE_DIV2) ? div_q[0] :
                  (sel == PRESCALE_DIV4) ? (&div_q[1:0]) : (&div_q);
endmodule
`default_nettype wire

/* wtc_edge_sync.sv */
// wtc_edge_sync: three-stage pin synchroniser with rising and falling edge pulses
`timescale 1ns/1ps
`default_nettype none
module wtc_edge_sync (
    input wire logic clock,
    input wire logic resetn,
    input wire logic pin,
    output logic rise,
    output logic fall
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic level_q;
    logic agree;
    always_ff @(posedge clock) begin
        if (!resetn) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end
    // only a level that both later stages agree on counts as a change
    assign agree = (s2_q == s3_q);
    always_ff @(posedge clock) begin
        if (!resetn) begin
            level_q <= 1'b0;
        end else if (agree) begin
            level_q <= s3_q;
        end
    end
    assign rise = agree & s3_q & ~level_q;
    assign fall = agree & ~s3_q & level_q;
endmodule
`default_nettype wire

/* wtc_top.sv */
// wtc_top: wide timer control, demodulation capture and avalon-mm register slave
`timescale 1ns/1ps
`default_nettype none
module wtc_top (
    input wire logic clock,
    input wire logic resetn,
    input wire logic stop_recovery,
    input wire wtc_pkg::wtc_avmm_req_t avs_req,
    output logic [wtc_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic capture_pin,
    input wire logic port_output_data,
    output logic timer_output_pin,
    output logic irq
);
    import wtc_pkg::*;

    // bus slave: one wait cycle, then the access completes
    logic ack_q;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;
    logic req_any;
    logic wr_go;
    logic [3:0] idx;
    logic idx_ok;
    logic [7:0] wdata8;

    assign req_any = avs_req.read | avs_req.write;
    assign avs_waitrequest = req_any & ~ack_q;
    assign wr_go = avs_req.write & ack_q;
    assign idx = avs_req.address[IDX_LSB +: 4];
    // the four index bits fill the address above the byte lane, so only alignment is checked
    assign idx_ok = (avs_req.address[IDX_LSB-1:0] == 2'h0);
    assign wdata8 = avs_req.writedata[7:0];
    assign avs_readdata = rdata_q;

    always_ff @(posedge clock) begin
        if (!resetn) begin
            ack_q <= 1'b0;
            rdata_q <= '0;
        end else begin
            ack_q <= req_any & ~ack_q;
            rdata_q <= rdata_d;
        end
    end

    wire wr_narrow = wr_go & idx_ok & (idx == IDX_NARROW_CTRL);
    wire wr_shared = wr_go & idx_ok & (idx == IDX_SHARED_CTRL);
    wire wr_wide = wr_go & idx_ok & (idx == IDX_WIDE_CTRL);
    wire wr_init = wr_go & idx_ok & (idx == IDX_WIDE_INIT);
    wire wr_status = wr_go & idx_ok & (idx == IDX_IRQ_STATUS);
    wire wr_mask = wr_go & idx_ok & (idx == IDX_IRQ_MASK);

    // wide counter control
    wtc_wide_ctrl_t wctl_q;
    wtc_wide_ctrl_t wctl_d;
    wtc_wide_ctrl_t wctl_w;
    logic [15:0] wide_init_q;
    logic [15:0] wide_cnt_q;
    logic [15:0] wide_cnt_d;
    logic wide_out_q;
    logic wide_tick;
    logic wide_at_tc;
    logic wide_tmo;
    logic wide_start;

    assign wctl_w = wtc_wide_ctrl_t'(wdata8);

    wtc_prescale u_prescale (
        .clock(clock),
        .resetn(resetn),
        .sel(wctl_q.counter_prescale_select),
        .tick(wide_tick)
    );

    assign wide_at_tc = (wide_cnt_q == WIDE_ZERO);
    assign wide_tmo = wctl_q.wide_counter_run & wide_tick & wide_at_tc;
    assign wide_start = wr_wide & wctl_w.wide_counter_run & ~wctl_q.wide_counter_run;

    always_comb begin
        wctl_d = wctl_q;
        if (wr_wide) begin
            wctl_d.wide_counter_run = wctl_w.wide_counter_run;
            wctl_d.single_pass = wctl_w.single_pass;
            wctl_d.counter_prescale_select = wctl_w.counter_prescale_select;
            wctl_d.capture_int_mask = wctl_w.capture_int_mask;
            wctl_d.counter_int_mask = wctl_w.counter_int_mask;
            wctl_d.pin_output_select = wctl_w.pin_output_select;
        end
        if (wide_tmo && wctl_q.single_pass && !wide_start) begin
            wctl_d.wide_counter_run = 1'b0;
        end
        wctl_d.time_out = w1c(wctl_q.time_out, wide_tmo, wr_wide & wctl_w.time_out);
        if (stop_recovery) begin
            // clock select and capture mask survive; the rest returns to reset
            wctl_d = WIDE_CTRL_RST;
            wctl_d.counter_prescale_select = wctl_q.counter_prescale_select;
            wctl_d.capture_int_mask = wctl_q.capture_int_mask;
        end
    end

    always_comb begin
        wide_cnt_d = wide_cnt_q;
        if (wide_start) begin
            wide_cnt_d = wide_init_q;
        end else if (wctl_q.wide_counter_run && wide_tick) begin
            if (wide_at_tc) begin
                // single pass holds at terminal count, modulo-n reloads
                wide_cnt_d = wctl_q.single_pass ? WIDE_ZERO : wide_init_q;
            end else begin
                wide_cnt_d = wide_cnt_q - 16'h0001;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            wctl_q <= WIDE_CTRL_RST;
            wide_init_q <= WIDE_INIT_RST;
            wide_cnt_q <= WIDE_ZERO;
            wide_out_q <= 1'b0;
            timer_output_pin <= 1'b0;
        end else begin
            wctl_q <= wctl_d;
            if (wr_init) begin
                wide_init_q <= avs_req.writedata[15:0];
            end
            wide_cnt_q <= wide_cnt_d;
            if (wide_tmo) begin
                wide_out_q <= ~wide_out_q;
            end
            timer_output_pin <= wctl_q.pin_output_select ? wide_out_q : port_output_data;
        end
    end

    // narrow counter and demodulation capture
    logic [7:0] nctl_q;
    logic [7:0] sctl_q;
    logic [7:0] narrow_cnt_q;
    logic [7:0] narrow_cnt_d;
    logic [7:0] cap_low_q;
    logic [7:0] cap_high_q;
    logic pin_rise;
    logic pin_fall;
    logic demod_on;
    logic cap_rise;
    logic cap_fall;
    logic narrow_tmo;

    wtc_edge_sync u_edge (
        .clock(clock),
        .resetn(resetn),
        .pin(capture_pin),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    assign demod_on = nctl_q[NC_RUN] & sctl_q[SC_DEMOD];
    assign cap_rise = demod_on & pin_rise;
    assign cap_fall = demod_on & pin_fall;
    // a capture reload outranks a same-cycle zero crossing
    assign narrow_tmo = demod_on & wide_tick & ~cap_rise & ~cap_fall &
                        (narrow_cnt_q == NARROW_ZERO);

    always_comb begin
        narrow_cnt_d = narrow_cnt_q;
        if (cap_rise || cap_fall) begin
            narrow_cnt_d = NARROW_RELOAD;
        end else if (narrow_tmo) begin
            narrow_cnt_d = NARROW_RELOAD;
        end else if (demod_on && wide_tick) begin
            narrow_cnt_d = narrow_cnt_q - 8'h01;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            nctl_q <= 8'h00;
            sctl_q <= 8'h00;
            narrow_cnt_q <= NARROW_RELOAD;
            cap_low_q <= 8'h00;
            cap_high_q <= 8'h00;
        end else begin
            if (wr_narrow) begin
                nctl_q[NC_RUN] <= wdata8[NC_RUN];
                nctl_q[NC_CAP_IE] <= wdata8[NC_CAP_IE];
                nctl_q[NC_TMO_IE] <= wdata8[NC_TMO_IE];
            end
            nctl_q[NC_TIMEOUT] <= w1c(nctl_q[NC_TIMEOUT], narrow_tmo,
                                      wr_narrow & wdata8[NC_TIMEOUT]);
            if (wr_shared) begin
                sctl_q[SC_DEMOD] <= wdata8[SC_DEMOD];
            end
            sctl_q[SC_RISE] <= w1c(sctl_q[SC_RISE], cap_rise, wr_shared & wdata8[SC_RISE]);
            sctl_q[SC_FALL] <= w1c(sctl_q[SC_FALL], cap_fall, wr_shared & wdata8[SC_FALL]);
            narrow_cnt_q <= narrow_cnt_d;
            if (cap_rise) begin
                cap_low_q <= narrow_cnt_q;
            end
            if (cap_fall) begin
                cap_high_q <= narrow_cnt_q;
            end
        end
    end

    // interrupt status, mask and output
    logic [IRQ_W-1:0] irq_stat_q;
    logic [IRQ_W-1:0] irq_mask_q;
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_clr;

    // capture needs both the narrow enable and the wide capture mask
    assign irq_set[IRQ_WIDE_TMO] = wide_tmo & wctl_q.counter_int_mask;
    assign irq_set[IRQ_CAPTURE] = (cap_rise | cap_fall) & nctl_q[NC_CAP_IE] &
                                  wctl_q.capture_int_mask;
    assign irq_set[IRQ_NARROW_TMO] = narrow_tmo & nctl_q[NC_TMO_IE];
    assign irq_clr = wr_status ? avs_req.writedata[IRQ_W-1:0] : '0;

    always_ff @(posedge clock) begin
        if (!resetn) begin
            irq_stat_q <= '0;
            irq_mask_q <= '0;
            irq <= 1'b0;
        end else begin
            for (int i = 0; i < IRQ_W; i++) begin
                irq_stat_q[i] <= w1c(irq_stat_q[i], irq_set[i], irq_clr[i]);
            end
            if (wr_mask) begin
                irq_mask_q <= avs_req.writedata[IRQ_W-1:0];
            end
            irq <= |(irq_stat_q & irq_mask_q);
        end
    end

    // read mux; unmapped or misaligned addresses read zero
    always_comb begin
        rdata_d = '0;
        if (avs_req.read && !ack_q && idx_ok) begin
            case (idx)
                IDX_NARROW_CTRL: rdata_d[7:0] = nctl_q;
                IDX_SHARED_CTRL: rdata_d[7:0] = sctl_q;
                IDX_WIDE_CTRL: rdata_d[7:0] = wctl_q;
                IDX_WIDE_INIT: rdata_d[15:0] = wide_init_q;
                IDX_WIDE_COUNT: rdata_d[15:0] = wide_cnt_q;
                IDX_CAPTURE_LOW: rdata_d[7:0] = cap_low_q;
                IDX_CAPTURE_HIGH: rdata_d[7:0] = cap_high_q;
                IDX_NARROW_COUNT: rdata_d[7:0] = narrow_cnt_q;
                IDX_IRQ_STATUS: rdata_d[IRQ_W-1:0] = irq_stat_q;
                IDX_IRQ_MASK: rdata_d[IRQ_W-1:0] = irq_mask_q;
                default: rdata_d = '0;
            endcase
        end
    end
endmodule
`default_nettype wire

/* wtc_top_asserts.sv */
// wtc_top_asserts: port-level checks for the wide timer control block
`timescale 1ns/1ps
`default_nettype none
module wtc_top_asserts (
    input wire logic clock,
    input wire logic resetn,
    input wire logic stop_recovery,
    input wire wtc_pkg::wtc_avmm_req_t avs_req,
    input wire logic [wtc_pkg::DATA_W-1:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic capture_pin,
    input wire logic port_output_data,
    input wire logic timer_output_pin,
    input wire logic irq
);
    import wtc_pkg::*;
    logic [7:0] ctl_q;
    logic [2:0] msk_q;
    wire logic rw = avs_req.read | avs_req.write;
    wire logic done = rw & ~avs_waitrequest;
    wire logic [3:0] idx = avs_req.address[5:2];
    wire logic at_ctl = avs_req.address == {IDX_WIDE_CTRL, 2'b00};
    wire logic at_msk = avs_req.address == {IDX_IRQ_MASK, 2'b00};
    wire logic rd_ctl = done & avs_req.read & at_ctl;
    wire logic bad = (idx > IDX_IRQ_MASK) || (avs_req.address[1:0] != 2'b00);
    // shadow of software-owned fields; hardware may only clear run and set timeout
    always_ff @(posedge clock) begin
        if (!resetn) begin
            ctl_q <= 8'h00;
            msk_q <= 3'h0;
        end else if (stop_recovery) begin
            ctl_q <= ctl_q & 8'h1c;
        end else if (done & avs_req.write) begin
            ctl_q <= at_ctl ? (avs_req.writedata[7:0] & 8'hdf) : ctl_q;
            msk_q <= at_msk ? avs_req.writedata[2:0] : msk_q;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    a_ctl_readback: assert property (rd_ctl |-> {avs_readdata[6], avs_readdata[4:0]} == {ctl_q[6], ctl_q[4:0]})
        else $error("control field readback differs from written value");
    a_run_written: assert property (rd_ctl && avs_readdata[7] |-> ctl_q[7])
        else $error("run bit reads one without being started");
    a_pin_follows: assert property ($past(resetn) && !ctl_q[0] && !$past(ctl_q[0])
        |-> timer_output_pin == $past(port_output_data))
        else $error("pin does not follow port data");
    a_irq_masked: assert property ($past(resetn) && msk_q == 3'h0 && $past(msk_q) == 3'h0 |-> !irq)
        else $error("interrupt raised with all masks clear");
    a_one_wait: assert property (rw && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered after one wait state");
    a_idle_ready: assert property (!rw |-> !avs_waitrequest)
        else $error("waitrequest high while idle");
    a_bad_zero: assert property (done && avs_req.read && bad |-> avs_readdata == '0)
        else $error("unmapped read returned data");
    a_upper_zero: assert property (done && avs_req.read && idx != IDX_WIDE_INIT
        && idx != IDX_WIDE_COUNT |-> avs_readdata[31:8] == 24'h000000)
        else $error("byte register upper bits not zero");
endmodule
bind wtc_top wtc_top_asserts u_chk (.clock(clock), .resetn(resetn),
    .stop_recovery(stop_recovery), .avs_req(avs_req), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .capture_pin(capture_pin),
    .port_output_data(port_output_data), .timer_output_pin(timer_output_pin), .irq(irq));
`default_nettype wire

/* tb_wide_timer_control_demod_capture.sv */
// tb_wide_timer_control_demod_capture: register-level testbench for the timer control block
`timescale 1ns/1ps
`default_nettype none
module tb_wide_timer_control_demod_capture;
    import wtc_pkg::*;
    localparam logic [3:0] CT = IDX_WIDE_CTRL;
    localparam logic [3:0] ST = IDX_IRQ_STATUS;
    localparam logic [3:0] MK = IDX_IRQ_MASK;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic stop_recovery = 1'b0;
    logic capture_pin = 1'b0;
    logic port_output_data = 1'b0;
    wtc_avmm_req_t avs_req = '0;
    logic [DATA_W-1:0] avs_readdata;
    logic avs_waitrequest;
    logic timer_output_pin;
    logic irq;
    logic [31:0] rd;
    logic s0;
    int failures = 0;
    int tests_run = 0;
    int cyc = 0;
    int a;
    int c0;
    int dv;
    always #10 clock = ~clock;
    wtc_top u_dut (.clock(clock), .resetn(resetn), .stop_recovery(stop_recovery),
        .avs_req(avs_req), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .capture_pin(capture_pin), .port_output_data(port_output_data),
        .timer_output_pin(timer_output_pin), .irq(irq));
    task automatic print_verdict();
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // runaway guard: the whole sequence needs well under 3000 cycles
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures = failures + 1;
            print_verdict();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // waitrequest and readdata are taken at the rising edge, before the slave's flops move
    task automatic bus(input logic w, input logic [3:0] i, input logic [31:0] d);
        @(posedge clock);
        avs_req.read <= ~w;
        avs_req.write <= w;
        avs_req.address <= {i, 2'b00};
        avs_req.writedata <= d;
        do begin
            @(posedge clock);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_req <= '0;
    endtask
    task automatic wr(input logic [3:0] i, input logic [31:0] d);
        bus(1'b1, i, d);
    endtask
    task automatic rc(input logic [3:0] i, input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, i, 32'h0);
        chk(rd & m, e);
    endtask
    initial begin
        repeat (6) @(posedge clock);
        resetn <= 1'b1;
        rc(CT, 32'hff, 32'h00);
        rc(IDX_WIDE_INIT, 32'hffff, 32'hffff);
        rc(4'hc, 32'hffffffff, 32'h0);
        for (int p = 0; p < 4; p++) begin
            wr(CT, {27'h0, p[1:0], 3'b111});
            rc(CT, 32'hff, {27'h0, p[1:0], 3'b111});
        end
        wr(IDX_WIDE_INIT, 32'h0fff);
        for (int p = 0; p < 4; p++) begin
            dv = 1 << p;
            wr(CT, {24'h0, 5'b10000 | p[1:0], 3'b000});
            bus(1'b0, IDX_WIDE_COUNT, 32'h0);
            a = int'(rd[15:0]);
            c0 = cyc;
            repeat (40) @(posedge clock);
            bus(1'b0, IDX_WIDE_COUNT, 32'h0);
            a = (a - int'(rd[15:0])) * dv;
            chk({31'h0, a <= cyc - c0 + dv && a + dv >= cyc - c0}, 32'h1);
            wr(CT, 32'h00);
            bus(1'b0, IDX_WIDE_COUNT, 32'h0);
            a = int'(rd[15:0]);
            rc(IDX_WIDE_COUNT, 32'hffff, a);
        end
        wr(IDX_WIDE_INIT, 32'h3);
        wr(CT, 32'hc0);
        repeat (20) @(posedge clock);
        rc(CT, 32'hff, 32'h60);
        rc(IDX_WIDE_COUNT, 32'hffff, 32'h0);
        wr(CT, 32'h40);
        rc(CT, 32'hff, 32'h60);
        wr(CT, 32'h60);
        rc(CT, 32'hff, 32'h40);
        wr(CT, 32'h81);
        repeat (20) @(posedge clock);
        rc(CT, 32'ha0, 32'ha0);
        @(negedge clock);
        s0 = timer_output_pin;
        repeat (4) @(negedge clock);
        chk({31'h0, s0 ^ timer_output_pin}, 32'h1);
        wr(CT, 32'h00);
        port_output_data <= 1'b1;
        repeat (3) @(posedge clock);
        chk({31'h0, timer_output_pin}, 32'h1);
        wr(MK, 32'h1);
        wr(CT, 32'hc0);
        repeat (20) @(posedge clock);
        rc(ST, 32'h7, 32'h0);
        wr(CT, 32'he2);
        repeat (20) @(posedge clock);
        chk({31'h0, irq}, 32'h1);
        rc(ST, 32'h7, 32'h1);
        wr(MK, 32'h0);
        repeat (3) @(posedge clock);
        chk({31'h0, irq}, 32'h0);
        wr(ST, 32'h1);
        wr(MK, 32'h1);
        repeat (3) @(posedge clock);
        chk({31'h0, irq}, 32'h0);
        wr(CT, 32'h04);
        wr(MK, 32'h2);
        wr(IDX_SHARED_CTRL, 32'h40);
        wr(IDX_NARROW_CTRL, 32'h84);
        capture_pin <= 1'b1;
        c0 = cyc;
        repeat (12) @(posedge clock);
        rc(IDX_SHARED_CTRL, 32'hff, 32'h42);
        chk({31'h0, irq}, 32'h1);
        bus(1'b0, IDX_CAPTURE_LOW, 32'h0);
        chk({31'h0, rd[7:0] >= 8'he8 && rd[7:0] <= 8'hfe}, 32'h1);
        capture_pin <= 1'b0;
        a = cyc - c0;
        repeat (12) @(posedge clock);
        rc(IDX_SHARED_CTRL, 32'hff, 32'h43);
        bus(1'b0, IDX_CAPTURE_HIGH, 32'h0);
        a = 255 - int'(rd[7:0]) - a;
        chk({31'h0, a >= -1 && a <= 1}, 32'h1);
        wr(IDX_SHARED_CTRL, 32'h43);
        rc(IDX_SHARED_CTRL, 32'hff, 32'h40);
        wr(IDX_NARROW_CTRL, 32'h86);
        wr(MK, 32'h4);
        repeat (270) @(posedge clock);
        rc(IDX_NARROW_CTRL, 32'h20, 32'h20);
        rc(ST, 32'h4, 32'h4);
        chk({31'h0, irq}, 32'h1);
        wr(CT, 32'hdf);
        stop_recovery <= 1'b1;
        @(posedge clock);
        stop_recovery <= 1'b0;
        rc(CT, 32'hdf, 32'h1c);
        resetn <= 1'b0;
        repeat (3) @(posedge clock);
        resetn <= 1'b1;
        rc(CT, 32'hff, 32'h00);
        print_verdict();
    end
endmodule
`default_nettype wire
